//--- verilog/spcpc_top.sv
// Clock output and serial port clock/data pin control, with receive word buffer.
// Assumes pins arrive unsynchronised; the bench resolves pin levels from _O/_OE.
//
// Functional notes
// - Master clock toggles twice per machine cycle, falling-edge bounded.
// - Disable bit stops driving master clock output.
// - Output-disable input low floats master clock.
// - Receive clock pin shifts incoming receive data.
// - Receive clock mode bit sets pin direction.
// - Receive GPIO enable frees receive clock, data.
// - Transmit clock shifts data; input when mode zero.
// - Sampled transmit clock level readable as status.
// - Transmit GPIO enable makes clock pin GPIO.
`timescale 1ns/1ps

// Synchronous FIFO with registered storage and honest full and empty.
module spcpc_fifo #(
  parameter int WIDTH = spcpc_pkg::WORD_WIDTH_DEF,
  parameter int DEPTH = spcpc_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import spcpc_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // Pointer arithmetic wraps naturally, so only powers of two are served.
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("spcpc_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Word storage.
  logic [AW:0] wr_ptr_r;  // Write pointer with wrap bit.
  logic [AW:0] rd_ptr_r;  // Read pointer with wrap bit.
  logic push;
  logic pop;

  assign in_ready = (wr_ptr_r - rd_ptr_r) != (AW + 1)'(DEPTH);
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign out_data = mem[rd_ptr_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage is written only; no reset is needed for data.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers move on accepted transfers only.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

// Top level: clock output, shift clock pins, GPIO reuse and receive path.
module spcpc_top #(
  parameter int MACHINE_HALF = spcpc_pkg::MACHINE_HALF_DEF,
  parameter int SHIFT_HALF = spcpc_pkg::SHIFT_HALF_DEF,
  parameter int WIDTH = spcpc_pkg::WORD_WIDTH_DEF,
  parameter int DEPTH = spcpc_pkg::FIFO_DEPTH_DEF
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CLOCK_OUT_DISABLE,
  input wire logic EMULATION_OUTPUT_DISABLE_N,
  output logic MASTER_CLOCK_OUT_O,
  output logic MASTER_CLOCK_OUT_OE,
  output logic MACHINE_CYCLE_START,
  input wire logic RX_CLOCK_MODE,
  input wire logic RX_GPIO_ENABLE,
  input wire logic RX_SHIFT_CLOCK_PIN_I,
  output logic RX_SHIFT_CLOCK_PIN_O,
  output logic RX_SHIFT_CLOCK_PIN_OE,
  input wire logic RX_SERIAL_DATA_PIN_I,
  input wire logic RX_CLK_GPIO_OUT,
  input wire logic RX_CLK_GPIO_DIR,
  output logic RX_CLK_GPIO_IN,
  output logic RX_DATA_GPIO_IN,
  output logic [WIDTH-1:0] RX_WORD,
  output logic RX_WORD_VALID,
  input wire logic RX_WORD_READY,
  output logic RX_STALLED,
  input wire logic TX_CLOCK_MODE,
  input wire logic TX_GPIO_ENABLE,
  input wire logic TX_SHIFT_CLOCK_PIN_I,
  output logic TX_SHIFT_CLOCK_PIN_O,
  output logic TX_SHIFT_CLOCK_PIN_OE,
  input wire logic TX_CLK_GPIO_OUT,
  input wire logic TX_CLK_GPIO_DIR,
  output logic TX_CLK_GPIO_IN,
  output logic TX_CLOCK_SAMPLE,
  output logic TX_SHIFT_TICK
);
  import spcpc_pkg::*;

  localparam int MC_PERIOD = 2 * MACHINE_HALF;  // MCLK cycles per machine cycle.
  localparam int BW = $clog2(WIDTH + 1);

  // Counters must fit at least one cycle per half period.
  initial begin
    if (MACHINE_HALF < 1 || SHIFT_HALF < 1 || WIDTH < 2) begin
      $error("spcpc_top: half periods must be at least 1 and WIDTH at least 2");
    end
  end

  logic [SYNC_NUM-1:0] pins;  // Raw pin inputs.
  logic [SYNC_NUM-1:0] s1_r;  // First stage, read only by the second.
  logic [SYNC_NUM-1:0] s2_r;
  logic [SYNC_NUM-1:0] s3_r;
  logic [SYNC_NUM-1:0] lvl_r;  // Accepted pin levels.
  logic [SYNC_NUM-1:0] lvl_d_r;  // Previous accepted levels for edge finding.

  // Each pin lands on its own bit, so no pin can leak into another's level.
  assign pins[SYNC_OFF_N] = EMULATION_OUTPUT_DISABLE_N;
  assign pins[SYNC_RXC] = RX_SHIFT_CLOCK_PIN_I;
  assign pins[SYNC_RXD] = RX_SERIAL_DATA_PIN_I;
  assign pins[SYNC_TXC] = TX_SHIFT_CLOCK_PIN_I;

  // Three-stage synchroniser; a change counts once stages two and three agree.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s1_r <= RST_SYNC;
      s2_r <= RST_SYNC;
      s3_r <= RST_SYNC;
      lvl_r <= RST_SYNC;
      lvl_d_r <= RST_SYNC;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r));
      lvl_d_r <= lvl_r;
    end
  end

  logic off_n;  // Low while the output-disable pin is held low.
  assign off_n = lvl_r[SYNC_OFF_N];

  // Master clock divider.
  logic [15:0] mc_cnt_r;
  logic master_clock_out_r;

  // The output falls at the start of each machine cycle and rises halfway.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mc_cnt_r <= '0;
      master_clock_out_r <= RST_MASTER_CLOCK_OUT;
      MACHINE_CYCLE_START <= 1'b0;
    end else begin
      MACHINE_CYCLE_START <= 1'b0;
      if (mc_cnt_r == 16'(MACHINE_HALF - 1)) begin
        mc_cnt_r <= '0;
        master_clock_out_r <= ~master_clock_out_r;
        MACHINE_CYCLE_START <= master_clock_out_r;
      end else begin
        mc_cnt_r <= mc_cnt_r + 16'h0001;
      end
    end
  end

  assign MASTER_CLOCK_OUT_O = master_clock_out_r;

  // Master clock enable: the disable bit and the output-disable pin both float it.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      MASTER_CLOCK_OUT_OE <= 1'b0;
    end else begin
      MASTER_CLOCK_OUT_OE <= ~CLOCK_OUT_DISABLE & off_n;
    end
  end

  // Shared divider for internally generated shift clocks.
  logic [15:0] sh_cnt_r;
  logic sh_tick;
  logic rx_int_clk_r;  // Internal receive shift clock.
  logic tx_int_clk_r;  // Internal transmit shift clock.
  logic stall;  // Receiver holds a full word not yet taken by the buffer.
  assign sh_tick = sh_cnt_r == 16'(SHIFT_HALF - 1);

  // The receive clock pauses while stalled, so an internal source really stops.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sh_cnt_r <= '0;
      rx_int_clk_r <= RST_SHIFT_CLK;
      tx_int_clk_r <= RST_SHIFT_CLK;
    end else begin
      sh_cnt_r <= sh_tick ? 16'h0000 : sh_cnt_r + 16'h0001;
      if (sh_tick) begin
        tx_int_clk_r <= ~tx_int_clk_r;
        if (!stall || rx_int_clk_r) begin
          rx_int_clk_r <= ~rx_int_clk_r;
        end
      end
    end
  end

  // Pin drivers; every enable is dropped while the output-disable pin is low.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RX_SHIFT_CLOCK_PIN_O <= 1'b0;
      RX_SHIFT_CLOCK_PIN_OE <= 1'b0;
      TX_SHIFT_CLOCK_PIN_O <= 1'b0;
      TX_SHIFT_CLOCK_PIN_OE <= 1'b0;
    end else begin
      if (RX_GPIO_ENABLE) begin
        RX_SHIFT_CLOCK_PIN_O <= RX_CLK_GPIO_OUT;
        RX_SHIFT_CLOCK_PIN_OE <= RX_CLK_GPIO_DIR & off_n;
      end else begin
        RX_SHIFT_CLOCK_PIN_O <= rx_int_clk_r;
        RX_SHIFT_CLOCK_PIN_OE <= RX_CLOCK_MODE & off_n;
      end
      if (TX_GPIO_ENABLE) begin
        TX_SHIFT_CLOCK_PIN_O <= TX_CLK_GPIO_OUT;
        TX_SHIFT_CLOCK_PIN_OE <= TX_CLK_GPIO_DIR & off_n;
      end else begin
        TX_SHIFT_CLOCK_PIN_O <= tx_int_clk_r;
        TX_SHIFT_CLOCK_PIN_OE <= TX_CLOCK_MODE & off_n;
      end
    end
  end

  // Status and GPIO input levels, all from synchronised samples.
  assign RX_CLK_GPIO_IN = lvl_r[SYNC_RXC];
  assign RX_DATA_GPIO_IN = lvl_r[SYNC_RXD];
  assign TX_CLK_GPIO_IN = lvl_r[SYNC_TXC];
  assign TX_CLOCK_SAMPLE = lvl_r[SYNC_TXC];

  // Rising shift-clock edges, from the pin or from the internal divider.
  logic rx_edge;
  logic tx_edge;
  logic rx_int_d_r;
  logic tx_int_d_r;
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_int_d_r <= RST_SHIFT_CLK;
      tx_int_d_r <= RST_SHIFT_CLK;
    end else begin
      rx_int_d_r <= rx_int_clk_r;
      tx_int_d_r <= tx_int_clk_r;
    end
  end
  assign rx_edge = RX_CLOCK_MODE ? (rx_int_clk_r & ~rx_int_d_r) : (lvl_r[SYNC_RXC] & ~lvl_d_r[SYNC_RXC]);
  assign tx_edge = TX_CLOCK_MODE ? (tx_int_clk_r & ~tx_int_d_r) : (lvl_r[SYNC_TXC] & ~lvl_d_r[SYNC_TXC]);

  // Transmit shift tick for the transmit register; silent while in GPIO use.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TX_SHIFT_TICK <= 1'b0;
    end else begin
      TX_SHIFT_TICK <= tx_edge & ~TX_GPIO_ENABLE;
    end
  end

  // Receive shifter: MSB first; a full word waits in HOLD until buffered.
  spcpc_rx_state_t rx_state_r;
  logic [WIDTH-1:0] rx_shift_r;
  logic [BW-1:0] bit_cnt_r;
  logic fifo_in_ready;
  assign stall = rx_state_r == SPCPC_RX_HOLD;
  assign RX_STALLED = stall;

  // Bits arriving during HOLD on an external clock are lost; RX_STALLED shows it.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_state_r <= SPCPC_RX_SHIFT;
      rx_shift_r <= '0;
      bit_cnt_r <= '0;
    end else begin
      case (rx_state_r)
        SPCPC_RX_SHIFT: begin
          if (RX_GPIO_ENABLE) begin
            bit_cnt_r <= '0;
          end else if (rx_edge) begin
            rx_shift_r <= {rx_shift_r[WIDTH-2:0], lvl_r[SYNC_RXD]};
            if (bit_cnt_r == BW'(WIDTH - 1)) begin
              bit_cnt_r <= '0;
              rx_state_r <= SPCPC_RX_HOLD;
            end else begin
              bit_cnt_r <= bit_cnt_r + 1'b1;
            end
          end
        end
        SPCPC_RX_HOLD: begin
          if (fifo_in_ready) begin
            rx_state_r <= SPCPC_RX_SHIFT;
          end
        end
        default: begin
          rx_state_r <= SPCPC_RX_SHIFT;
        end
      endcase
    end
  end

  spcpc_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst(SYS_RST),
    .in_data(rx_shift_r),
    .in_valid(stall),
    .in_ready(fifo_in_ready),
    .out_data(RX_WORD),
    .out_valid(RX_WORD_VALID),
    .out_ready(RX_WORD_READY)
  );

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  // Five low samples cover three synchroniser stages, the agreement stage and the enable register.
  sequence off_held;
    (!EMULATION_OUTPUT_DISABLE_N) [*5];
  endsequence
  sequence mc_fall;
    $fell(MASTER_CLOCK_OUT_O);
  endsequence

  AST_MASTER_CLOCK_OUT_PERIOD: assert property (mc_fall |-> ##MC_PERIOD $fell(MASTER_CLOCK_OUT_O))
    else $error("master clock period wrong");
  AST_CYCLE_ON_FALL: assert property (MACHINE_CYCLE_START == $fell(MASTER_CLOCK_OUT_O))
    else $error("machine cycle start not on falling edge");
  AST_CLOCK_OUT_DISABLE: assert property (CLOCK_OUT_DISABLE |=> !MASTER_CLOCK_OUT_OE)
    else $error("master clock driven while disabled");
  AST_OFF_MASTER_CLOCK_OUT: assert property (off_held |=> !MASTER_CLOCK_OUT_OE)
    else $error("master clock driven while output-disable low");
  AST_OFF_SERIAL: assert property (off_held |=> !RX_SHIFT_CLOCK_PIN_OE && !TX_SHIFT_CLOCK_PIN_OE)
    else $error("serial clock pin driven while output-disable low");
  AST_RX_DIR: assert property (!RX_GPIO_ENABLE && off_n |=> RX_SHIFT_CLOCK_PIN_OE == $past(RX_CLOCK_MODE))
    else $error("receive clock direction wrong");
  AST_RX_GPIO: assert property (RX_GPIO_ENABLE && off_n |=>
    RX_SHIFT_CLOCK_PIN_OE == $past(RX_CLK_GPIO_DIR) && RX_SHIFT_CLOCK_PIN_O == $past(RX_CLK_GPIO_OUT))
    else $error("receive clock pin not in GPIO use");
  AST_TX_INPUT: assert property (!TX_GPIO_ENABLE && !TX_CLOCK_MODE |=> !TX_SHIFT_CLOCK_PIN_OE)
    else $error("transmit clock driven in input mode");
  AST_TX_SAMPLE: assert property ($stable(TX_SHIFT_CLOCK_PIN_I) [*4] |=> TX_CLOCK_SAMPLE == $past(TX_SHIFT_CLOCK_PIN_I, 2))
    else $error("transmit clock sample stale");
  AST_TX_GPIO_TICK: assert property (TX_GPIO_ENABLE |=> !TX_SHIFT_TICK)
    else $error("shift tick during transmit GPIO use");
  AST_RX_SHIFT: assert property (rx_edge && !stall && !RX_GPIO_ENABLE |=> bit_cnt_r != $past(bit_cnt_r))
    else $error("receive edge did not shift");
endmodule

//--- verilog/spcpc_pkg.sv
// Package for the serial port clock pin control block: constants and types.
// Assumes one 200 MHz system clock; all users import the whole package.
package spcpc_pkg;

  // Period of MCLK in picoseconds, kept for reference; no count is derived from it.
  localparam int MCLK_PERIOD_PS = 5000;
  // Default MCLK cycles in one half of the master clock output period.
  localparam int MACHINE_HALF_DEF = 2;
  // Default MCLK cycles in one half of an internally made shift clock.
  localparam int SHIFT_HALF_DEF = 4;
  // Default received word width and buffer depth.
  localparam int WORD_WIDTH_DEF = 8;
  localparam int FIFO_DEPTH_DEF = 16;

  // Bit positions of the pins in the shared synchroniser vector.
  localparam int SYNC_OFF_N = 0;
  localparam int SYNC_RXC = 1;
  localparam int SYNC_RXD = 2;
  localparam int SYNC_TXC = 3;
  localparam int SYNC_NUM = 4;

  // Reset values; pins with pull-ups are assumed high before the first sample.
  localparam logic [3:0] RST_SYNC = 4'hf;
  localparam logic RST_MASTER_CLOCK_OUT = 1'b0;
  localparam logic RST_SHIFT_CLK = 1'b0;

  // Receiver states: shifting bits, or holding a full word for the buffer.
  typedef enum logic [0:0] {
    SPCPC_RX_SHIFT = 1'b0,
    SPCPC_RX_HOLD = 1'b1
  } spcpc_rx_state_t;

endpackage

//--- verif/spcpc_codec_model.sv
// Behavioural model of the external codec that feeds the receive clock and data pins.
// Assumes the bench resolves pin levels; the clock idles high as its pull-up would hold it.
`timescale 1ns/1ps

module spcpc_codec_model #(
  parameter int HALF_NS = 32
) (
  output logic link_clk,
  output logic link_data
);
  // The clock line rests at its pull-up level outside frames.
  initial begin
    link_clk = 1'b1;
    link_data = 1'b0;
  end

  // Sends one word MSB first; data changes on the falling edge so it is settled at the rise.
  task automatic send_word(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      link_clk = 1'b0;
      link_data = w[i];
      #(HALF_NS);
      link_clk = 1'b1;
      #(HALF_NS);
    end
    // The data line has no pull-up, so it shows the inverse of the last bit when released.
    link_data = ~w[0];
    // A quiet gap keeps the release and the next word's first bit in different time steps.
    #(HALF_NS);
  endtask
endmodule

//--- verif/spcpc_top_tb_top.sv
// Self-checking bench for the clock output and serial clock pin control block.
// Assumes the codec model drives the receive pins; this bench resolves the two shift clock pin levels.
`timescale 1ns/1ps

module spcpc_top_tb_top;
  import spcpc_pkg::*;
  logic MCLK = 1'b0, SYS_RST = 1'b1, CLOCK_OUT_DISABLE = 1'b0, EMULATION_OUTPUT_DISABLE_N = 1'b1;
  logic RX_CLOCK_MODE = 1'b0, RX_GPIO_ENABLE = 1'b0, RX_CLK_GPIO_OUT = 1'b0, RX_CLK_GPIO_DIR = 1'b0;
  logic TX_CLOCK_MODE = 1'b0, TX_GPIO_ENABLE = 1'b0, TX_CLK_GPIO_OUT = 1'b0, TX_CLK_GPIO_DIR = 1'b0;
  logic RX_WORD_READY = 1'b0, tx_drive = 1'b1;
  logic MASTER_CLOCK_OUT_O, MASTER_CLOCK_OUT_OE, MACHINE_CYCLE_START, RX_SHIFT_CLOCK_PIN_O;
  logic RX_SHIFT_CLOCK_PIN_OE, RX_CLK_GPIO_IN, RX_DATA_GPIO_IN, RX_WORD_VALID, RX_STALLED;
  logic TX_SHIFT_CLOCK_PIN_O, TX_SHIFT_CLOCK_PIN_OE, TX_CLK_GPIO_IN, TX_CLOCK_SAMPLE, TX_SHIFT_TICK;
  logic [7:0] RX_WORD;
  logic link_clk, link_data;
  int failures = 0;
  int compares = 0;

  // Pin levels: the device wins when it drives, otherwise the outside party or the pull-up.
  wire rx_clk_pin = RX_SHIFT_CLOCK_PIN_OE ? RX_SHIFT_CLOCK_PIN_O : link_clk;
  wire tx_clk_pin = TX_SHIFT_CLOCK_PIN_OE ? TX_SHIFT_CLOCK_PIN_O : tx_drive;

  always #2.5 MCLK = ~MCLK;

  spcpc_codec_model #(.HALF_NS(32)) u_codec (.link_clk(link_clk), .link_data(link_data));

  spcpc_top u_dut (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .CLOCK_OUT_DISABLE(CLOCK_OUT_DISABLE),
    .EMULATION_OUTPUT_DISABLE_N(EMULATION_OUTPUT_DISABLE_N), .MASTER_CLOCK_OUT_O(MASTER_CLOCK_OUT_O),
    .MASTER_CLOCK_OUT_OE(MASTER_CLOCK_OUT_OE), .MACHINE_CYCLE_START(MACHINE_CYCLE_START),
    .RX_CLOCK_MODE(RX_CLOCK_MODE), .RX_GPIO_ENABLE(RX_GPIO_ENABLE), .RX_SHIFT_CLOCK_PIN_I(rx_clk_pin),
    .RX_SHIFT_CLOCK_PIN_O(RX_SHIFT_CLOCK_PIN_O), .RX_SHIFT_CLOCK_PIN_OE(RX_SHIFT_CLOCK_PIN_OE),
    .RX_SERIAL_DATA_PIN_I(link_data), .RX_CLK_GPIO_OUT(RX_CLK_GPIO_OUT), .RX_CLK_GPIO_DIR(RX_CLK_GPIO_DIR),
    .RX_CLK_GPIO_IN(RX_CLK_GPIO_IN), .RX_DATA_GPIO_IN(RX_DATA_GPIO_IN), .RX_WORD(RX_WORD),
    .RX_WORD_VALID(RX_WORD_VALID), .RX_WORD_READY(RX_WORD_READY), .RX_STALLED(RX_STALLED),
    .TX_CLOCK_MODE(TX_CLOCK_MODE), .TX_GPIO_ENABLE(TX_GPIO_ENABLE), .TX_SHIFT_CLOCK_PIN_I(tx_clk_pin),
    .TX_SHIFT_CLOCK_PIN_O(TX_SHIFT_CLOCK_PIN_O), .TX_SHIFT_CLOCK_PIN_OE(TX_SHIFT_CLOCK_PIN_OE),
    .TX_CLK_GPIO_OUT(TX_CLK_GPIO_OUT), .TX_CLK_GPIO_DIR(TX_CLK_GPIO_DIR), .TX_CLK_GPIO_IN(TX_CLK_GPIO_IN),
    .TX_CLOCK_SAMPLE(TX_CLOCK_SAMPLE), .TX_SHIFT_TICK(TX_SHIFT_TICK)
  );

  // Moves n cycles on; inputs change 1 ns after the last edge so the edge never races them.
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  // Single comparison point for every check.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Measures the spacing of machine cycle starts and checks they land on a falling edge.
  task automatic master_clock_case();
    int gap;
    int seen_starts;
    gap = 0;
    seen_starts = 0;
    for (int i = 0; i < 40 && seen_starts < 2; i++) begin
      tick(1);
      gap++;
      if (MACHINE_CYCLE_START === 1'b1) begin
        check(MASTER_CLOCK_OUT_O, 1'b0);
        if (seen_starts == 1) check(gap, 2 * MACHINE_HALF_DEF);
        seen_starts++;
        gap = 0;
      end
    end
    check(seen_starts, 2);
    check(MASTER_CLOCK_OUT_OE, 1'b1);
    CLOCK_OUT_DISABLE = 1'b1;
    tick(2);
    check(MASTER_CLOCK_OUT_OE, 1'b0);
    CLOCK_OUT_DISABLE = 1'b0;
    tick(2);
    check(MASTER_CLOCK_OUT_OE, 1'b1);
  endtask

  // Direction bits drive the pins; output-disable low floats every driven pin.
  task automatic direction_case();
    RX_CLOCK_MODE = 1'b1;
    TX_CLOCK_MODE = 1'b1;
    tick(2);
    check({RX_SHIFT_CLOCK_PIN_OE, TX_SHIFT_CLOCK_PIN_OE}, 2'b11);
    EMULATION_OUTPUT_DISABLE_N = 1'b0;
    tick(8);
    check({MASTER_CLOCK_OUT_OE, RX_SHIFT_CLOCK_PIN_OE, TX_SHIFT_CLOCK_PIN_OE}, 3'b000);
    EMULATION_OUTPUT_DISABLE_N = 1'b1;
    RX_CLOCK_MODE = 1'b0;
    TX_CLOCK_MODE = 1'b0;
    tick(8);
    check({MASTER_CLOCK_OUT_OE, RX_SHIFT_CLOCK_PIN_OE, TX_SHIFT_CLOCK_PIN_OE}, 3'b100);
  endtask

  // Transmit clock as input: its level is readable and each rise gives one shift tick.
  task automatic tx_sample_case();
    int ticks;
    ticks = 0;
    tx_drive = 1'b0;
    tick(8);
    check(TX_CLOCK_SAMPLE, 1'b0);
    check(TX_SHIFT_CLOCK_PIN_OE, 1'b0);
    tx_drive = 1'b1;
    for (int i = 0; i < 10; i++) begin
      tick(1);
      if (TX_SHIFT_TICK === 1'b1) ticks++;
    end
    check(ticks, 1);
    check(TX_CLOCK_SAMPLE, 1'b1);
  endtask

  // Both sides handed over to general-purpose use, driving and then reading.
  task automatic gpio_case();
    RX_GPIO_ENABLE = 1'b1;
    TX_GPIO_ENABLE = 1'b1;
    RX_CLK_GPIO_DIR = 1'b1;
    TX_CLK_GPIO_DIR = 1'b1;
    TX_CLK_GPIO_OUT = 1'b1;
    tick(3);
    check({RX_SHIFT_CLOCK_PIN_OE, RX_SHIFT_CLOCK_PIN_O}, 2'b10);
    check({TX_SHIFT_CLOCK_PIN_OE, TX_SHIFT_CLOCK_PIN_O}, 2'b11);
    RX_CLK_GPIO_DIR = 1'b0;
    TX_CLK_GPIO_DIR = 1'b0;
    tx_drive = 1'b0;
    tick(8);
    check({RX_CLK_GPIO_IN, RX_DATA_GPIO_IN}, {1'b1, link_data});
    check(TX_CLK_GPIO_IN, 1'b0);
    RX_GPIO_ENABLE = 1'b0;
    TX_GPIO_ENABLE = 1'b0;
    tx_drive = 1'b1;
    tick(8);
  endtask

  // Seventeen words with the reader stalled: sixteen fill the buffer, one waits, then all drain in order.
  task automatic receive_case();
    logic [7:0] exp_q[$];
    int got;
    got = 0;
    #7;
    for (int w = 0; w < 17; w++) begin
      exp_q.push_back(8'h5a ^ 8'(w * 8'h13));
      u_codec.send_word(exp_q[w]);
    end
    tick(20);
    check({RX_STALLED, RX_WORD_VALID}, 2'b11);
    RX_WORD_READY = 1'b1;
    // The head is judged before the edge that pops it, so the first word is seen too.
    for (int i = 0; i < 200 && got < 17; i++) begin
      if (RX_WORD_VALID === 1'b1) begin
        check(RX_WORD, exp_q[got]);
        got++;
      end
      tick(1);
    end
    check(got, 17);
    tick(4);
    check({RX_STALLED, RX_WORD_VALID}, 2'b00);
    RX_WORD_READY = 1'b0;
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence: reset for four cycles, then each scenario in turn.
  initial begin
    tick(3);
    check({MASTER_CLOCK_OUT_OE, TX_SHIFT_CLOCK_PIN_OE, TX_CLOCK_SAMPLE}, 3'b001);
    tick(1);
    SYS_RST = 1'b0;
    tick(2);
    master_clock_case();
    direction_case();
    tx_sample_case();
    gpio_case();
    receive_case();
    end_of_test();
  end
endmodule
